// ===== test/serial_tx_model.sv
`timescale 1ns/1ps
// remote transmitter on the receive line, idle high
module serial_tx_model (
    input wire logic ref_clk,
    output logic rx_serial
);
    initial begin
        rx_serial = 1'b1;
    end

    // hold one line level for n clocks, changed just after an edge
    task automatic drive(input logic v, input int n);
        rx_serial <= v;
        repeat (n) @(posedge ref_clk);
    endtask

    // start, n data bits lsb first, optional parity, stop of st clocks
    task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pv,
            input logic stop, input int bt, input int st);
        drive(1'b0, bt);
        for (int i = 0; i < n; i++) begin
            drive(d[i], bt);
        end
        if (pen) begin
            drive(pv, bt);
        end
        drive(stop, st);
        if (!stop) begin
            drive(1'b1, bt); // back to idle after a broken stop
        end
    endtask

    // short low spike, then idle
    task automatic pulse(input int n);
        drive(1'b0, n);
        drive(1'b1, 1);
    endtask
endmodule

// ===== test/uart_async_rx_recovery_tb.sv
`timescale 1ns/1ps
module uart_async_rx_recovery_tb;
    import uart_rx_pkg::*;
    logic ref_clk;
    logic reset;
    logic sample_tick = 1'b0;
    logic rx_serial;
    logic [ADDR_W-1:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, irq, err, clk_en;
    logic [31:0] pwdata, prdata, rd;
    int miscompares = 0;
    int checked = 0;
    int tick_cnt = 0;

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // oversample tick every fourth clock
    always @(posedge ref_clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        sample_tick <= (tick_cnt == 3);
    end

    uart_async_rx_recovery u_uart_async_rx_recovery (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .sample_tick(sample_tick),
        .rx_serial(rx_serial), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq)
    );

    serial_tx_model u_serial_tx_model (
        .ref_clk(ref_clk),
        .rx_serial(rx_serial)
    );

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, m, seen, exp);
        end
    endtask

    // one apb transfer, result in rd and err
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        check(rd, exp, m);
    endtask

    // wait for the interrupt, bounded
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check({31'h0, irq}, 32'h1, "irq");
    endtask

    // unmask, wait, compare sticky status, clear it
    task automatic ev(input logic [31:0] mk, input logic [31:0] st);
        apb(1'b1, MASK_ADDR, mk);
        wait_irq();
        rdchk(STATUS_ADDR, st, "status");
        apb(1'b1, STATUS_ADDR, st);
        #1;
        check({31'h0, irq}, 32'h0, "irq clear");
        rdchk(STATUS_ADDR, 32'h0, "status clear");
    endtask

    // verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rdchk(CTRL_ADDR, 32'h0, "ctrl reset");
        rdchk(LINE_ADDR, 32'h0, "idle line");
        check({31'h0, irq}, 32'h0, "irq reset");
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped");
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");
        apb(1'b1, CTRL_ADDR, 32'h31);
        fork
            u_serial_tx_model.send(8'hA5, 8, 1'b0, 1'b0, 1'b1, 64, 64);
            ev(32'h1, 32'h1);
        join
        rdchk(DATA_ADDR, 32'hA5, "8n1 data");
        rdchk(LINE_ADDR, 32'h0, "full cleared");
        $display("test normal frame done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, CTRL_ADDR, 32'h31 | (m << 1));
            fork
                u_serial_tx_model.pulse((m ? 4 : 8) * 4);
                ev(32'h8, 32'h8);
            join
            rdchk(LINE_ADDR, 32'h0, "hunting");
            fork
                u_serial_tx_model.pulse((m ? 5 : 9) * 4);
                ev(32'h1, 32'h1);
            join
            rdchk(DATA_ADDR, 32'hFF, "late high");
        end
        $display("test start vote done");
        apb(1'b1, CTRL_ADDR, 32'h27);
        fork
            u_serial_tx_model.send(8'h5A, 7, 1'b1, ~^(7'h5A), 1'b0, 32, 32);
            ev(32'h7, 32'h7);
        join
        rdchk(DATA_ADDR, 32'h35A, "errors stored");
        $display("test double speed done");
        // five data bits with correct odd parity
        apb(1'b1, CTRL_ADDR, 32'h0D);
        fork
            u_serial_tx_model.send(8'h13, 5, 1'b1, ~^(5'h13), 1'b1, 64, 64);
            ev(32'h1, 32'h1);
        join
        rdchk(DATA_ADDR, 32'h13, "odd parity");
        $display("test odd parity done");
        // six data bits, second frame arrives while the first is unread
        apb(1'b1, CTRL_ADDR, 32'h11);
        fork
            begin
                u_serial_tx_model.send(8'h2A, 6, 1'b0, 1'b0, 1'b1, 64, 64);
                u_serial_tx_model.send(8'h15, 6, 1'b0, 1'b0, 1'b1, 64, 64);
            end
            ev(32'h10, 32'h11);
        join
        rdchk(DATA_ADDR, 32'h2A, "overrun keeps first");
        rdchk(LINE_ADDR, 32'h0, "overrun drained");
        $display("test overrun done");
        apb(1'b1, CTRL_ADDR, 32'h31);
        fork
            begin
                u_serial_tx_model.send(8'h3C, 8, 1'b0, 1'b0, 1'b1, 64, 40);
                u_serial_tx_model.send(8'hC3, 8, 1'b0, 1'b0, 1'b1, 64, 64);
            end
            begin
                apb(1'b1, MASK_ADDR, 32'h1);
                wait_irq();
                rdchk(DATA_ADDR, 32'h3C, "first");
                apb(1'b1, STATUS_ADDR, 32'h1);
            end
        join
        rdchk(LINE_ADDR, 32'h1, "second full");
        while (rd[0] === 1'b1) begin
            rdchk(DATA_ADDR, 32'hC3, "second");
            apb(1'b0, LINE_ADDR, 32'h0);
        end
        check(rd, 32'h0, "flushed");
        $display("test early start done");
        // clock enable low through the access phase holds off pready
        fork
            apb(1'b0, CTRL_ADDR, 32'h0);
            begin
                repeat (2) @(posedge ref_clk);
                clk_en <= 1'b0;
                repeat (3) @(posedge ref_clk);
                check({31'h0, pready}, 32'h0, "frozen ready");
                clk_en <= 1'b1;
            end
        join
        check(rd, 32'h31, "frozen read");
        $display("test clock enable done");
        close_out();
    end
endmodule

// ===== verilog/majority_vote.sv
`timescale 1ns/1ps
module majority_vote (
    input wire logic a,
    input wire logic b,
    input wire logic c,
    output logic y
);
    // two of three wins
    assign y = (a & b) | (a & c) | (b & c);
endmodule

// ===== verilog/rx_sync.sv
`timescale 1ns/1ps
module rx_sync
    import uart_rx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    logic [SYNC_STAGES-1:0] stage_q;
    logic agree;

    assign agree = (stage_q[2] == stage_q[1]);

    // three stages, output follows once the last two agree
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stage_q <= {SYNC_STAGES{IDLE_LEVEL}};
            dout <= IDLE_LEVEL;
        end else if (clk_en) begin
            stage_q <= {stage_q[1:0], din};
            if (agree) begin
                dout <= stage_q[1];
            end
        end
    end

    sync_agree_a: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(dout) |-> $past(agree) && $past(clk_en))
        else $error("synchronised line changed without agreement");

endmodule

// ===== verilog/uart_async_rx_recovery.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module uart_async_rx_recovery
    import uart_rx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic rx_serial,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    ctrl_type ctrl_q;
    event_type status_q;
    event_type mask_q;
    event_type events;
    frame_type frame_q;
    rx_state_type state_q;
    rx_state_type bit_next;
    logic rx_full_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_mux;
    logic line;
    logic line_prev_q;
    logic [SAMPLE_W-1:0] sample_q;
    logic [SAMPLE_W-1:0] sample_n;
    logic [SAMPLE_W-1:0] bit_len;
    logic [SAMPLE_W-1:0] vote_first;
    logic [SAMPLE_W-1:0] vote_last;
    logic [3:0] bit_idx_q;
    logic [3:0] data_bits;
    logic [DATA_W-1:0] shift_q;
    logic [DATA_W-1:0] aligned;
    logic [1:0] vote_q;
    logic par_q;
    logic step;
    logic busy;
    logic vote_bit;
    logic vote_now;
    logic bit_end;
    logic in_vote;
    logic frame_done;
    logic noise;
    logic par_err_now;
    logic start_edge;
    logic acc;
    logic setup;
    logic mapped;
    logic data_rd;
    logic load_frame;

    // line synchroniser and voter
    rx_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .din(rx_serial),
        .dout(line)
    );

    majority_vote u_vote (
        .a(vote_q[1]),
        .b(vote_q[0]),
        .c(line),
        .y(vote_bit)
    );

    // timing of one bit in the selected speed
    assign step = clk_en & sample_tick;
    assign busy = (state_q != ST_IDLE);
    assign bit_len = ctrl_q.double_speed_select ? DBL_SAMPLES : NORM_SAMPLES;
    assign vote_first = ctrl_q.double_speed_select ? DBL_VOTE_FIRST : NORM_VOTE_FIRST;
    assign vote_last = vote_first + VOTE_SPAN;
    assign sample_n = (sample_q == bit_len) ? SAMPLE_ONE : sample_q + SAMPLE_ONE;
    assign in_vote = (sample_n >= vote_first) && (sample_n <= vote_last);
    assign vote_now = step && busy && (sample_n == vote_last);
    assign bit_end = step && busy && (sample_n == bit_len);
    assign start_edge = line_prev_q && !line;
    assign noise = vote_now && (state_q == ST_START) && vote_bit;
    assign frame_done = vote_now && (state_q == ST_STOP);
    assign data_bits = MIN_DATA_BITS + {2'b00, ctrl_q.char_size};
    assign aligned = shift_q >> (DATA_BITS_MAX - data_bits);
    assign par_err_now = ctrl_q.parity_en && (par_q != ctrl_q.parity_odd);

    // state following the current bit
    always_comb begin
        case (state_q)
            ST_START: bit_next = ST_DATA;
            ST_DATA: begin
                if (bit_idx_q != data_bits - 4'h1) begin
                    bit_next = ST_DATA;
                end else if (ctrl_q.parity_en) begin
                    bit_next = ST_PARITY;
                end else begin
                    bit_next = ST_STOP;
                end
            end
            ST_PARITY: bit_next = ST_STOP;
            ST_STOP: bit_next = ST_STOP;
            default: bit_next = ST_IDLE;
        endcase
    end

    // recovery state and sample number
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            sample_q <= SAMPLE_ZERO;
        end else if (clk_en) begin
            if (!ctrl_q.rx_enable) begin
                state_q <= ST_IDLE;
                sample_q <= SAMPLE_ZERO;
            end else if (sample_tick) begin
                if (!busy) begin
                    if (start_edge) begin
                        state_q <= ST_START;
                        sample_q <= SAMPLE_ONE;
                    end else begin
                        sample_q <= SAMPLE_ZERO;
                    end
                end else if (noise || frame_done) begin
                    state_q <= ST_IDLE;
                    sample_q <= SAMPLE_ZERO;
                end else begin
                    sample_q <= sample_n;
                    if (sample_n == bit_len) begin
                        state_q <= bit_next;
                    end
                end
            end
        end
    end

    // previous line sample for edge detection
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            line_prev_q <= IDLE_LEVEL;
        end else if (step) begin
            line_prev_q <= line;
        end
    end

    // centre samples kept for the vote
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vote_q <= '0;
        end else if (step && busy && in_vote) begin
            vote_q <= {vote_q[0], line};
        end
    end

    // data bit counter, restarted at each start bit
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bit_idx_q <= '0;
        end else if (bit_end) begin
            if (state_q == ST_START) begin
                bit_idx_q <= '0;
            end else if (state_q == ST_DATA) begin
                bit_idx_q <= bit_idx_q + 4'h1;
            end
        end
    end

    // voted data and parity accumulation
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shift_q <= '0;
            par_q <= 1'b0;
        end else if (bit_end && state_q == ST_START) begin
            par_q <= 1'b0;
        end else if (vote_now && state_q == ST_DATA) begin
            shift_q <= {vote_bit, shift_q[DATA_W-1:1]};
            par_q <= par_q ^ vote_bit;
        end else if (vote_now && state_q == ST_PARITY) begin
            par_q <= par_q ^ vote_bit;
        end
    end

    // register access decode
    assign acc = psel & penable & clk_en;
    assign setup = psel & ~penable & clk_en;
    assign mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) || (paddr == MASK_ADDR) ||
                    (paddr == DATA_ADDR) || (paddr == LINE_ADDR);
    assign pready = acc;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_q;
    assign data_rd = acc && !pwrite && (paddr == DATA_ADDR);
    assign load_frame = frame_done && (!rx_full_q || data_rd);

    // received frame holding register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frame_q <= '0;
            rx_full_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q.rx_enable) begin
                rx_full_q <= 1'b0;
            end else if (load_frame) begin
                frame_q <= {par_err_now, !vote_bit, aligned};
                rx_full_q <= 1'b1;
            end else if (data_rd) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // events of this frame
    always_comb begin
        events = EVENT_NONE;
        events.done = load_frame;
        events.frame_err = frame_done && !vote_bit;
        events.parity_err = frame_done && par_err_now;
        events.noise = noise;
        events.overrun = frame_done && !load_frame;
    end

    // control, mask and sticky status; a new event wins over the clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            mask_q <= EVENT_NONE;
            status_q <= EVENT_NONE;
        end else if (clk_en) begin
            if (acc && pwrite && paddr == CTRL_ADDR) begin
                ctrl_q <= pwdata[$bits(ctrl_type)-1:0];
            end
            if (acc && pwrite && paddr == MASK_ADDR) begin
                mask_q <= pwdata[$bits(event_type)-1:0];
            end
            if (acc && pwrite && paddr == STATUS_ADDR) begin
                status_q <= (status_q & ~event_type'(pwdata[$bits(event_type)-1:0])) | events;
            end else begin
                status_q <= status_q | events;
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // read mux
    always_comb begin
        rdata_mux = '0;
        case (paddr)
            CTRL_ADDR: rdata_mux[$bits(ctrl_type)-1:0] = ctrl_q;
            STATUS_ADDR: rdata_mux[$bits(event_type)-1:0] = status_q;
            MASK_ADDR: rdata_mux[$bits(event_type)-1:0] = mask_q;
            DATA_ADDR: rdata_mux[$bits(frame_type)-1:0] = frame_q;
            LINE_ADDR: begin
                rdata_mux[LINE_FULL_BIT] = rx_full_q;
                rdata_mux[LINE_BUSY_BIT] = busy;
                rdata_mux[LINE_SAMPLE_LSB +: SAMPLE_W] = sample_q;
            end
            default: rdata_mux = '0;
        endcase
    end

    // read data captured in the setup cycle; clk_en must be high in that cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_mux;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    idle_zero_a: assert property (state_q == ST_IDLE |-> sample_q == SAMPLE_ZERO)
        else $error("idle sample number not zero");
    sample_range_a: assert property (busy |-> sample_q >= SAMPLE_ONE && sample_q <= bit_len)
        else $error("sample number out of bit range");
    speed_limit_a: assert property (ctrl_q.double_speed_select && busy |-> sample_q <= DBL_SAMPLES)
        else $error("double speed exceeded eight samples");
    start_first_a: assert property (step && ctrl_q.rx_enable && !busy && line_prev_q && !line
        |=> state_q == ST_START && sample_q == SAMPLE_ONE)
        else $error("start edge not numbered as sample one");
    noise_reject_a: assert property (step && ctrl_q.rx_enable && state_q == ST_START &&
        sample_n == vote_last && vote_q == 2'b11 |=> state_q == ST_IDLE)
        else $error("noisy start bit accepted");
    start_align_a: assert property (step && ctrl_q.rx_enable && state_q == ST_START &&
        sample_n == bit_len
        |=> state_q == ST_DATA && sample_q == bit_len && bit_idx_q == 4'h0)
        else $error("data not aligned after start bit");
    data_vote_a: assert property (vote_now && state_q == ST_DATA
        |=> shift_q[DATA_W-1] == $past(vote_bit))
        else $error("data bit not the majority");
    frame_flag_a: assert property (ctrl_q.rx_enable && frame_done && !vote_bit && !rx_full_q
        |=> rx_full_q && frame_q.frame_error_flag && status_q.frame_err)
        else $error("low stop bit did not flag frame error");
    early_start_a: assert property (ctrl_q.rx_enable && frame_done |=> state_q == ST_IDLE)
        else $error("stop bit not ended at its vote");
    vote_sample_a: assert property (step && busy && ctrl_q.rx_enable && !noise && !frame_done
        |=> sample_q == $past(sample_n))
        else $error("sample number did not advance");

    noise_c: cover property (noise);
    frame_ok_c: cover property (load_frame && vote_bit);
    frame_err_c: cover property (frame_done && !vote_bit);
    double_frame_c: cover property (ctrl_q.double_speed_select && load_frame);

endmodule

// ===== verilog/uart_rx_pkg.sv
package uart_rx_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 5;
    localparam int SYNC_STAGES = 3;
    localparam logic IDLE_LEVEL = 1'b1;

    // sample numbering per bit
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 5'h00;
    localparam logic [SAMPLE_W-1:0] SAMPLE_ONE = 5'h01;
    localparam logic [SAMPLE_W-1:0] NORM_SAMPLES = 5'h10;
    localparam logic [SAMPLE_W-1:0] DBL_SAMPLES = 5'h08;
    localparam logic [SAMPLE_W-1:0] NORM_VOTE_FIRST = 5'h08;
    localparam logic [SAMPLE_W-1:0] DBL_VOTE_FIRST = 5'h04;
    localparam logic [SAMPLE_W-1:0] VOTE_SPAN = 5'h02;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] DATA_BITS_MAX = 4'h8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] DATA_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] LINE_ADDR = 8'h10;

    // line register fields
    localparam int LINE_FULL_BIT = 0;
    localparam int LINE_BUSY_BIT = 1;
    localparam int LINE_SAMPLE_LSB = 8;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} rx_state_type;

    typedef struct packed {
        logic [1:0] char_size;
        logic parity_odd;
        logic parity_en;
        logic double_speed_select;
        logic rx_enable;
    } ctrl_type;

    typedef struct packed {
        logic overrun;
        logic noise;
        logic parity_err;
        logic frame_err;
        logic done;
    } event_type;

    typedef struct packed {
        logic parity_err;
        logic frame_error_flag;
        logic [DATA_W-1:0] data;
    } frame_type;

    localparam ctrl_type CTRL_RESET = '0;
    localparam event_type EVENT_NONE = '0;

endpackage
